// >>> gbuc_avg_filter.sv
// Channel 2 temperature tracking average with difference limiter.
// Assumes one sample at most per cycle; average held as 12.4 fixed point.
`include "gbuc_defs.svh"

module gbuc_avg_filter
  import gbuc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  gbuc_filt_if.filt fif
);
  typedef struct packed {
    logic [`GBUC_FX_W-1:0] avg_fx;
    logic primed;
    logic out_valid;
  } gbuc_filt_state_type;

  gbuc_filt_state_type st_reg, st_next;
  logic signed [`GBUC_DATA_W:0] diff;
  logic signed [`GBUC_DATA_W:0] lim;
  logic signed [`GBUC_FX_W:0] step;

  // ----------------------------------------------------------------
  // Averaging step
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.out_valid = 1'b0;
    diff = $signed({1'b0, fif.sample}) - $signed({1'b0, st_reg.avg_fx[`GBUC_FX_W-1:`GBUC_FRAC_W]});
    lim = $signed(13'((13'h0001 << fif.limit_code) - 13'h0001));
    if (fif.limit_code != 3'h0) begin
      if (diff > lim) begin
        diff = lim;
      end else if (diff < -lim) begin
        diff = -lim;
      end
    end
    // Difference is in whole LSBs; the 4 fraction bits make 1/16 a plain add
    step = fif.eq_sel ? 17'($signed(diff) * 4) : 17'($signed(diff));
    if (!fif.enable) begin
      st_next.primed = 1'b0;
    end else if (fif.sample_valid) begin
      st_next.out_valid = 1'b1;
      st_next.primed = 1'b1;
      if (!st_reg.primed) begin
        st_next.avg_fx = {fif.sample, 4'h0};
      end else begin
        st_next.avg_fx = 16'($signed({1'b0, st_reg.avg_fx}) + step);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fif.avg_valid = st_reg.out_valid;
  assign fif.avg = st_reg.avg_fx[`GBUC_FX_W-1:`GBUC_FRAC_W];

  a_limit_step: assert property (@(posedge mclk) disable iff (rst)
    fif.enable && fif.sample_valid && st_reg.primed && !fif.eq_sel && fif.limit_code == 3'h1
    |=> (st_reg.avg_fx - $past(st_reg.avg_fx) <= 16'h0001) || ($past(st_reg.avg_fx) - st_reg.avg_fx <= 16'h0001))
    else $error("limited average moved by more than one sixteenth");
  c_filter_quarter: cover property (@(posedge mclk) disable iff (rst)
    fif.enable && fif.eq_sel && fif.sample_valid && st_reg.primed);
endmodule

// >>> gbuc_defs.svh
// Constants of the gate bias update control block: register indices, field positions, timing.
// Assumes inclusion by gbuc_pkg and the design modules; definitions only.
`ifndef GBUC_DEFS_SVH
`define GBUC_DEFS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define GBUC_ADDR_W 5
`define GBUC_A_SOFT_CFG 5'h00
`define GBUC_A_FILT_CFG 5'h01
`define GBUC_A_PWR_HYST 5'h02
`define GBUC_A_TEMP_HYST 5'h03
`define GBUC_A_DAC_IN1 5'h04
`define GBUC_A_DAC_IN2 5'h05
`define GBUC_A_DAC_BOTH1 5'h06
`define GBUC_A_DAC_BOTH2 5'h07
`define GBUC_A_LOAD_DAC 5'h08
`define GBUC_A_AMP_CAL 5'h09
`define GBUC_A_ADC_CONV 5'h0A
`define GBUC_A_SETPOINT1 5'h0B
`define GBUC_A_SETPOINT2 5'h0C
`define GBUC_A_PWR_PARAM1 5'h0D
`define GBUC_A_PWR_PARAM2 5'h0E
`define GBUC_A_DAC_OUT1 5'h10
`define GBUC_A_DAC_OUT2 5'h11
`define GBUC_A_STATUS 5'h12
`define GBUC_A_CH2_AVG 5'h13

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GBUC_AVGCTL_BIT 15
`define GBUC_LIMIT_MSB 14
`define GBUC_LIMIT_LSB 12
`define GBUC_CH_STRIDE 6
`define GBUC_LDSEL_OFS 5
`define GBUC_TEMP_COMP_OFS 4
`define GBUC_PWR_COMP_OFS 3
`define GBUC_SRC_HI_OFS 1
`define GBUC_SRC_LO_OFS 0
`define GBUC_CAL_TRACK_BIT 0
`define GBUC_CAL_NOW_BIT 1
`define GBUC_CAL_SELF_BIT 2
`define GBUC_ADC_CONT_BIT 7
`define GBUC_DATA_W 12
`define GBUC_REG_W 16
`define GBUC_HYST_W 4
`define GBUC_ADC_CH 7
`define GBUC_FRAC_W 4
`define GBUC_FX_W 16

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define GBUC_SOFT_CFG_RST 16'h0000
`define GBUC_CAL_PERIOD_MS 13
`define GBUC_NS_PER_MS 1000000
`define GBUC_CLK_PERIOD_NS 10
`define GBUC_CNT_W 21

`endif

// >>> gbuc_filt_if.sv
// Link between the control block and the channel 2 temperature averaging filter.
// Assumes both ends run on the same clock.
interface gbuc_filt_if;
  import gbuc_pkg::*;
  logic enable;
  logic eq_sel;
  logic [2:0] limit_code;
  logic sample_valid;
  gbuc_code_type sample;
  logic avg_valid;
  gbuc_code_type avg;

  modport filt (input enable, eq_sel, limit_code, sample_valid, sample, output avg_valid, avg);
  modport ctrl (output enable, eq_sel, limit_code, sample_valid, sample, input avg_valid, avg);
endinterface

// >>> gbuc_pkg.sv
// Types shared by the gate bias update control modules.
// Assumes gbuc_defs.svh is on the include path.
`include "gbuc_defs.svh"

package gbuc_pkg;
  typedef logic [`GBUC_DATA_W-1:0] gbuc_code_type;

  typedef enum logic [2:0] {
    GBUC_CAL_IDLE = 3'b001,
    GBUC_CAL_RUN = 3'b010,
    GBUC_CAL_WAIT = 3'b100
  } gbuc_cal_type;

  typedef enum logic [1:0] {
    GBUC_SRC_PARAM = 2'b00,
    GBUC_SRC_RSVD = 2'b01,
    GBUC_SRC_DRAIN = 2'b10,
    GBUC_SRC_AUX = 2'b11
  } gbuc_src_type;
endpackage

// >>> gbuc_top.sv
// Gate bias update control: calculation triggers, DAC register loading, PGA calibration, ADC select.
// Assumes a register master that never waits and an outside LUT engine answering calc_start.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`include "gbuc_defs.svh"

// Behaviour
// - Channel 2 average adds 1/16 or 1/4
// - Limiter code n (1-7) clamps difference to 2^n-1; code 0 disables the limiter
// - Source code selects parameter, drain, or auxiliary
// - Shared hysteresis gates power sample triggers
// - Input write stores 12 bits, output unchanged
// - Load write copies input into output
// - Input write starts no calculation
// - Combined write loads both, no calculation
// - DAC registers never go to nonvolatile store
// - Calibration register keeps three bits, saved
// - Tracking bit picks acquisition or tracking mode
// - Calibrate-now starts both, clears when done unless self-timed
// - Powered-down channel skips its calibration
// - Self-timed mode repeats every 13 ms
// - Temperature change beyond hysteresis starts calculation
// - Setpoint write always starts calculation
// - Parameter write starts calculation, source 00
// - Sample source change starts calculation
// - Seven channel enables plus continuous bit
// - ADC register write starts a conversion
// - Load-select routes results to input/output
// - Filter settings only while filter enabled
module gbuc_top
  import gbuc_pkg::*;
#(
  parameter int unsigned CAL_PERIOD_CYCLES = `GBUC_CAL_PERIOD_MS * `GBUC_NS_PER_MS / `GBUC_CLK_PERIOD_NS
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`GBUC_ADDR_W-1:0] reg_addr,
  input wire logic [`GBUC_REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`GBUC_REG_W-1:0] reg_rdata,
  input wire logic [1:0] temp_valid,
  input wire logic [1:0][`GBUC_DATA_W-1:0] temp_sample,
  input wire logic [1:0] drain_valid,
  input wire logic [1:0][`GBUC_DATA_W-1:0] drain_sample,
  input wire logic [1:0] aux_valid,
  input wire logic [1:0][`GBUC_DATA_W-1:0] aux_input_sample,
  input wire logic [1:0] ch_powered_down,
  input wire logic [1:0] calc_done,
  input wire logic [1:0][`GBUC_DATA_W-1:0] gate_voltage_result,
  input wire logic pga_cal_done,
  output logic [1:0] calc_start,
  output logic [1:0][`GBUC_DATA_W-1:0] power_control_parameter,
  output logic [1:0][`GBUC_DATA_W-1:0] temp_value,
  output logic [1:0][`GBUC_DATA_W-1:0] bias_setpoint,
  output logic [1:0][`GBUC_DATA_W-1:0] gate_dac_code,
  output logic pga_cal_start,
  output logic [1:0] pga_cal_mask,
  output logic pga_cal_track,
  output logic [2:0] nvm_cal_image,
  output logic adc_start,
  output logic [`GBUC_ADC_CH-1:0] adc_channel_enable,
  output logic adc_continuous
);
  typedef struct packed {
    logic [`GBUC_REG_W-1:0] soft_cfg;
    logic filt_en;
    logic [`GBUC_HYST_W-1:0] pwr_hyst;
    gbuc_code_type temp_hyst;
    logic [1:0][`GBUC_DATA_W-1:0] dac_in;
    logic [1:0][`GBUC_DATA_W-1:0] dac_out;
    logic [1:0][`GBUC_DATA_W-1:0] setpoint;
    logic [1:0][`GBUC_DATA_W-1:0] pwr_param;
    logic [1:0][`GBUC_DATA_W-1:0] pwr_last;
    logic [1:0][`GBUC_DATA_W-1:0] temp_last;
    logic [1:0] calc_start;
    logic cal_track;
    logic cal_now;
    logic cal_self;
    gbuc_cal_type cal_state;
    logic [`GBUC_CNT_W-1:0] cal_cnt;
    logic cal_start;
    logic [1:0] cal_mask;
    logic [`GBUC_ADC_CH-1:0] adc_sel;
    logic adc_cont;
    logic adc_start;
    logic [`GBUC_REG_W-1:0] rdata;
  } gbuc_state_type;

  localparam logic [`GBUC_CNT_W-1:0] CAL_RELOAD = `GBUC_CNT_W'(CAL_PERIOD_CYCLES - 1);

  gbuc_state_type st_reg, st_next;
  gbuc_filt_if fif ();
  logic [1:0] t_valid;
  logic [1:0][`GBUC_DATA_W-1:0] t_val;
  logic [1:0] p_valid;
  logic [1:0][`GBUC_DATA_W-1:0] p_val;
  logic [1:0] ldsel, temp_comp_en, pwr_comp_en;
  logic [1:0][1:0] src;
  logic wr_hit;

  function automatic gbuc_code_type absdiff(input gbuc_code_type a, input gbuc_code_type b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  // ----------------------------------------------------------------
  // Channel 2 averaging filter
  // ----------------------------------------------------------------
  assign fif.enable = st_reg.filt_en;
  assign fif.eq_sel = st_reg.soft_cfg[`GBUC_AVGCTL_BIT];
  assign fif.limit_code = st_reg.soft_cfg[`GBUC_LIMIT_MSB:`GBUC_LIMIT_LSB];
  assign fif.sample_valid = temp_valid[1];
  assign fif.sample = temp_sample[1];

  gbuc_avg_filter gbuc_avg_filter_i (
    .mclk(mclk),
    .rst(rst),
    .fif(fif)
  );

  // ----------------------------------------------------------------
  // Per-channel sample selection
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign ldsel[c] = st_reg.soft_cfg[c*`GBUC_CH_STRIDE+`GBUC_LDSEL_OFS];
    assign temp_comp_en[c] = st_reg.soft_cfg[c*`GBUC_CH_STRIDE+`GBUC_TEMP_COMP_OFS];
    assign pwr_comp_en[c] = st_reg.soft_cfg[c*`GBUC_CH_STRIDE+`GBUC_PWR_COMP_OFS];
    assign src[c] = st_reg.soft_cfg[c*`GBUC_CH_STRIDE+`GBUC_SRC_HI_OFS:c*`GBUC_CH_STRIDE+`GBUC_SRC_LO_OFS];
    // Channel 2 reads the tracking average only while the filter is on
    if (c == 1) begin : g_filt
      assign t_valid[c] = st_reg.filt_en ? fif.avg_valid : temp_valid[c];
      assign t_val[c] = st_reg.filt_en ? fif.avg : temp_sample[c];
    end else begin : g_raw
      assign t_valid[c] = temp_valid[c];
      assign t_val[c] = temp_sample[c];
    end
    // Reserved source 01 takes no samples
    assign p_valid[c] = (src[c] == GBUC_SRC_AUX) ? aux_valid[c] :
      (src[c] == GBUC_SRC_DRAIN) ? drain_valid[c] : 1'b0;
    assign p_val[c] = (src[c] == GBUC_SRC_AUX) ? aux_input_sample[c] : drain_sample[c];
  end

  assign wr_hit = reg_wr && reg_addr == `GBUC_A_AMP_CAL;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.calc_start = 2'b00;
    st_next.cal_start = 1'b0;
    st_next.adc_start = 1'b0;
    st_next.rdata = '0;

    for (int c = 0; c < 2; c++) begin
      if (temp_comp_en[c] && t_valid[c] && absdiff(t_val[c], st_reg.temp_last[c]) > st_reg.temp_hyst) begin
        st_next.calc_start[c] = 1'b1;
        st_next.temp_last[c] = t_val[c];
      end
      if (pwr_comp_en[c] && p_valid[c] && src[c][1] &&
          absdiff(p_val[c], st_reg.pwr_last[c]) > `GBUC_DATA_W'(st_reg.pwr_hyst)) begin
        st_next.calc_start[c] = 1'b1;
        st_next.pwr_last[c] = p_val[c];
      end
      if (calc_done[c]) begin
        st_next.dac_in[c] = gate_voltage_result[c];
        if (!ldsel[c]) begin
          st_next.dac_out[c] = gate_voltage_result[c];
        end
      end
    end

    // Calibration sequencer
    case (st_reg.cal_state)
      GBUC_CAL_IDLE: begin
        if (st_reg.cal_now) begin
          if (&ch_powered_down) begin
            st_next.cal_now = st_reg.cal_self;
            st_next.cal_cnt = CAL_RELOAD;
            st_next.cal_state = st_reg.cal_self ? GBUC_CAL_WAIT : GBUC_CAL_IDLE;
          end else begin
            st_next.cal_start = 1'b1;
            st_next.cal_mask = ~ch_powered_down;
            st_next.cal_state = GBUC_CAL_RUN;
          end
        end
      end
      GBUC_CAL_RUN: begin
        if (pga_cal_done) begin
          st_next.cal_now = st_reg.cal_self;
          st_next.cal_cnt = CAL_RELOAD;
          st_next.cal_state = st_reg.cal_self ? GBUC_CAL_WAIT : GBUC_CAL_IDLE;
        end
      end
      GBUC_CAL_WAIT: begin
        if (!st_reg.cal_now || !st_reg.cal_self) begin
          st_next.cal_state = GBUC_CAL_IDLE;
        end else if (st_reg.cal_cnt == '0) begin
          st_next.cal_state = GBUC_CAL_IDLE;
        end else begin
          st_next.cal_cnt = st_reg.cal_cnt - `GBUC_CNT_W'(1);
        end
      end
      default: begin
        st_next.cal_state = GBUC_CAL_IDLE;
      end
    endcase

    // Register writes come last so software wins over same-cycle hardware updates
    if (reg_wr) begin
      case (reg_addr)
        `GBUC_A_SOFT_CFG: st_next.soft_cfg = reg_wdata;
        `GBUC_A_FILT_CFG: st_next.filt_en = reg_wdata[0];
        `GBUC_A_PWR_HYST: st_next.pwr_hyst = reg_wdata[`GBUC_HYST_W-1:0];
        `GBUC_A_TEMP_HYST: st_next.temp_hyst = reg_wdata[`GBUC_DATA_W-1:0];
        `GBUC_A_DAC_IN1: st_next.dac_in[0] = reg_wdata[`GBUC_DATA_W-1:0];
        `GBUC_A_DAC_IN2: st_next.dac_in[1] = reg_wdata[`GBUC_DATA_W-1:0];
        `GBUC_A_DAC_BOTH1: begin
          st_next.dac_in[0] = reg_wdata[`GBUC_DATA_W-1:0];
          st_next.dac_out[0] = reg_wdata[`GBUC_DATA_W-1:0];
        end
        `GBUC_A_DAC_BOTH2: begin
          st_next.dac_in[1] = reg_wdata[`GBUC_DATA_W-1:0];
          st_next.dac_out[1] = reg_wdata[`GBUC_DATA_W-1:0];
        end
        `GBUC_A_LOAD_DAC: st_next.dac_out = st_reg.dac_in;
        `GBUC_A_AMP_CAL: begin
          st_next.cal_track = reg_wdata[`GBUC_CAL_TRACK_BIT];
          st_next.cal_now = reg_wdata[`GBUC_CAL_NOW_BIT];
          st_next.cal_self = reg_wdata[`GBUC_CAL_SELF_BIT];
        end
        `GBUC_A_ADC_CONV: begin
          st_next.adc_sel = reg_wdata[`GBUC_ADC_CH-1:0];
          st_next.adc_cont = reg_wdata[`GBUC_ADC_CONT_BIT];
          st_next.adc_start = 1'b1;
        end
        `GBUC_A_SETPOINT1, `GBUC_A_SETPOINT2: begin
          st_next.setpoint[reg_addr[0] ? 0 : 1] = reg_wdata[`GBUC_DATA_W-1:0];
          st_next.calc_start[reg_addr[0] ? 0 : 1] = 1'b1;
        end
        `GBUC_A_PWR_PARAM1, `GBUC_A_PWR_PARAM2: begin
          st_next.pwr_param[reg_addr[0] ? 0 : 1] = reg_wdata[`GBUC_DATA_W-1:0];
          if (pwr_comp_en[reg_addr[0] ? 0 : 1] && src[reg_addr[0] ? 0 : 1] == GBUC_SRC_PARAM) begin
            st_next.calc_start[reg_addr[0] ? 0 : 1] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Write-only registers and unmapped indices read as zero
    if (reg_rd) begin
      case (reg_addr)
        `GBUC_A_DAC_OUT1: st_next.rdata = `GBUC_REG_W'(st_reg.dac_out[0]);
        `GBUC_A_DAC_OUT2: st_next.rdata = `GBUC_REG_W'(st_reg.dac_out[1]);
        `GBUC_A_STATUS: st_next.rdata = `GBUC_REG_W'({st_reg.cal_state == GBUC_CAL_RUN, st_reg.cal_now});
        `GBUC_A_CH2_AVG: st_next.rdata = `GBUC_REG_W'(fif.avg);
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.soft_cfg <= `GBUC_SOFT_CFG_RST;
      st_reg.cal_state <= GBUC_CAL_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Only the calibration bits leave for the nonvolatile store; DAC codes never do
  assign nvm_cal_image = {st_reg.cal_self, st_reg.cal_now, st_reg.cal_track};
  assign reg_rdata = st_reg.rdata;
  assign calc_start = st_reg.calc_start;
  assign temp_value = st_reg.temp_last;
  assign bias_setpoint = st_reg.setpoint;
  assign gate_dac_code = st_reg.dac_out;
  assign pga_cal_start = st_reg.cal_start;
  assign pga_cal_mask = st_reg.cal_mask;
  assign pga_cal_track = st_reg.cal_track;
  assign adc_start = st_reg.adc_start;
  assign adc_channel_enable = st_reg.adc_sel;
  assign adc_continuous = st_reg.adc_cont;
  for (genvar c = 0; c < 2; c++) begin : g_apc
    assign power_control_parameter[c] = (src[c] == GBUC_SRC_PARAM) ? st_reg.pwr_param[c] : st_reg.pwr_last[c];
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_input_hold: assert property (@(posedge mclk) disable iff (rst)
    reg_wr && reg_addr == `GBUC_A_DAC_IN1 && !calc_done[0]
    |=> st_reg.dac_in[0] == $past(reg_wdata[`GBUC_DATA_W-1:0]) && st_reg.dac_out[0] == $past(st_reg.dac_out[0]))
    else $error("input write disturbed the output code");
  a_load_copy: assert property (@(posedge mclk) disable iff (rst)
    reg_wr && reg_addr == `GBUC_A_LOAD_DAC |=> st_reg.dac_out == $past(st_reg.dac_in))
    else $error("load write did not copy the input codes");
  a_dac_no_calc: assert property (@(posedge mclk) disable iff (rst)
    reg_wr && (reg_addr == `GBUC_A_DAC_IN1 || reg_addr == `GBUC_A_DAC_BOTH2) && !(|t_valid) && !(|p_valid)
    |=> calc_start == 2'b00)
    else $error("DAC write started a calculation");
  a_both_load: assert property (@(posedge mclk) disable iff (rst)
    reg_wr && reg_addr == `GBUC_A_DAC_BOTH2
    |=> st_reg.dac_out[1] == $past(reg_wdata[`GBUC_DATA_W-1:0]) && st_reg.dac_in[1] == st_reg.dac_out[1])
    else $error("combined write did not load both codes");
  a_setpoint_calc: assert property (@(posedge mclk) disable iff (rst)
    reg_wr && reg_addr == `GBUC_A_SETPOINT2 |=> calc_start[1])
    else $error("setpoint write did not start a calculation");
  a_param_calc: assert property (@(posedge mclk) disable iff (rst)
    reg_wr && reg_addr == `GBUC_A_PWR_PARAM1 && pwr_comp_en[0] && src[0] == GBUC_SRC_PARAM |=> calc_start[0])
    else $error("parameter write did not start a calculation");
  a_result_route: assert property (@(posedge mclk) disable iff (rst)
    calc_done[0] && !reg_wr |=> st_reg.dac_in[0] == $past(gate_voltage_result[0]) &&
    st_reg.dac_out[0] == ($past(ldsel[0]) ? $past(st_reg.dac_out[0]) : $past(gate_voltage_result[0])))
    else $error("result routed against the load select");
  a_cal_clear: assert property (@(posedge mclk) disable iff (rst)
    st_reg.cal_state == GBUC_CAL_RUN && pga_cal_done && !st_reg.cal_self && !wr_hit
    |=> !st_reg.cal_now ##1 !pga_cal_start)
    else $error("calibrate-now not cleared after calibration");
  a_cal_skip: assert property (@(posedge mclk) disable iff (rst)
    pga_cal_start |-> pga_cal_mask == ~$past(ch_powered_down))
    else $error("calibration mask ignores power-down");
  a_adc_start: assert property (@(posedge mclk) disable iff (rst)
    reg_wr && reg_addr == `GBUC_A_ADC_CONV |=> adc_start && adc_channel_enable == $past(reg_wdata[`GBUC_ADC_CH-1:0]))
    else $error("conversion write did not start the ADC");
  c_self_timed: cover property (@(posedge mclk) disable iff (rst)
    st_reg.cal_state == GBUC_CAL_WAIT ##1 st_reg.cal_state == GBUC_CAL_IDLE);
  c_temp_calc: cover property (@(posedge mclk) disable iff (rst) temp_comp_en[1] && st_reg.filt_en && t_valid[1]);
  c_drain_calc: cover property (@(posedge mclk) disable iff (rst) pwr_comp_en[0] && p_valid[0] && src[0][1]);
  a_pwr_hyst: assert property (@(posedge mclk) disable iff (rst)
    !reg_wr && !t_valid[0] && p_valid[0] && absdiff(p_val[0], st_reg.pwr_last[0]) <= `GBUC_DATA_W'(st_reg.pwr_hyst)
    |=> !calc_start[0])
    else $error("sample within the hysteresis started a calculation");
  a_adc_cont: assert property (@(posedge mclk) disable iff (rst)
    reg_wr && reg_addr == `GBUC_A_ADC_CONV |=> adc_continuous == $past(reg_wdata[`GBUC_ADC_CONT_BIT]))
    else $error("continuous bit not taken from the conversion write");
endmodule

// >>> gbuc_top_tb.sv
// Self-checking bench for gbuc_top: DAC loading, calculation triggers, calibration, ADC select.
// Assumes gbuc_defs.svh on the include path; the bench is register master, sample source and LUT engine.
`include "gbuc_defs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end

module gbuc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gbuc_pkg::*;
  localparam int CAL_CYC = 20;
  typedef struct packed {logic [4:0] a; logic [15:0] d; logic [11:0] e0; logic [11:0] e1;} gbuc_row_type;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pga_cal_done = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [1:0] temp_valid = 2'h0, drain_valid = 2'h0, aux_valid = 2'h0, ch_powered_down = 2'h0, calc_done = 2'h0;
  logic [1:0][11:0] temp_sample = '0, drain_sample = '0, aux_input_sample = '0, gate_voltage_result = '0;
  logic [1:0][11:0] power_control_parameter, temp_value, bias_setpoint, gate_dac_code;
  logic [1:0] calc_start, pga_cal_mask;
  logic pga_cal_start, pga_cal_track, adc_start, adc_continuous;
  logic [2:0] nvm_cal_image;
  logic [6:0] adc_channel_enable;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, n_calc = 0, k;
  // Plain DAC writes; none of these may start a calculation
  gbuc_row_type rows [6] = '{'{5'h04, 16'hF123, 12'h000, 12'h000}, '{5'h08, 16'h0000, 12'h123, 12'h000},
    '{5'h07, 16'hA456, 12'h123, 12'h456}, '{5'h05, 16'hF789, 12'h123, 12'h456},
    '{5'h08, 16'h0000, 12'h123, 12'h789}, '{5'h06, 16'h5FED, 12'hFED, 12'h789}};

  gbuc_top #(.CAL_PERIOD_CYCLES(CAL_CYC)) gbuc_top_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_valid(temp_valid),
    .temp_sample(temp_sample), .drain_valid(drain_valid), .drain_sample(drain_sample), .aux_valid(aux_valid),
    .aux_input_sample(aux_input_sample), .ch_powered_down(ch_powered_down), .calc_done(calc_done),
    .gate_voltage_result(gate_voltage_result), .pga_cal_done(pga_cal_done), .calc_start(calc_start),
    .power_control_parameter(power_control_parameter), .temp_value(temp_value), .bias_setpoint(bias_setpoint),
    .gate_dac_code(gate_dac_code), .pga_cal_start(pga_cal_start), .pga_cal_mask(pga_cal_mask),
    .pga_cal_track(pga_cal_track), .nvm_cal_image(nvm_cal_image), .adc_start(adc_start),
    .adc_channel_enable(adc_channel_enable), .adc_continuous(adc_continuous));

  always #5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Watchdog and calculation counter
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    cyc++;
    if (calc_start[0] === 1'b1) n_calc++;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(negedge mclk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    `CHK(reg_rdata, e)
  endtask

  // Feeds one channel 2 temperature sample, then reads back the tracking average
  task automatic avg(input logic [11:0] s, input logic [15:0] e);
    @(posedge mclk);
    temp_valid <= 2'b10;
    temp_sample <= {s, 12'h000};
    @(posedge mclk);
    temp_valid <= 2'b00;
    rd(5'h13, e);
  endtask

  // Feeds one channel 1 sample and checks whether a calculation follows
  task automatic smp(input logic drain, input logic [11:0] s, input logic e);
    @(posedge mclk);
    if (drain) drain_valid <= 2'b01;
    else temp_valid <= 2'b01;
    drain_sample <= {12'h000, s};
    temp_sample <= {12'h000, s};
    @(posedge mclk);
    drain_valid <= 2'b00;
    temp_valid <= 2'b00;
    @(negedge mclk);
    `CHK(calc_start[0], e)
  endtask

  task automatic result(input logic [11:0] r, input logic [11:0] e);
    @(posedge mclk);
    calc_done <= 2'b01;
    gate_voltage_result <= {r, r};
    @(posedge mclk);
    calc_done <= 2'b00;
    @(negedge mclk);
    `CHK(gate_dac_code[0], e)
  endtask

  // Waits a bounded time for a calibration start, then answers it
  task automatic wait_cal(input logic [1:0] m, input logic t);
    for (k = 0; k < CAL_CYC + 10 && pga_cal_start !== 1'b1; k++) @(negedge mclk);
    `CHK({pga_cal_start, pga_cal_mask, pga_cal_track}, {1'b1, m, t})
    @(posedge mclk);
    pga_cal_done <= 1'b1;
    @(posedge mclk);
    pga_cal_done <= 1'b0;
    @(negedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK({gate_dac_code, calc_start, nvm_cal_image, adc_continuous}, 30'h0)
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      `CHK({gate_dac_code, calc_start}, {rows[i].e1, rows[i].e0, 2'b00})
    end
    `CHK(n_calc, 0)
    rd(5'h10, 16'h0FED);
    rd(5'h11, 16'h0789);
    rd(5'h1F, 16'h0000);
    rd(5'h09, 16'h0000);
    wr(5'h0B, 16'hF2A5);
    `CHK({calc_start, bias_setpoint[0]}, {2'b01, 12'h2A5})
    wr(5'h00, 16'h0028);
    wr(5'h0D, 16'h0321);
    `CHK({calc_start[0], power_control_parameter[0]}, {1'b1, 12'h321})
    result(12'hABC, 12'hFED);
    wr(5'h08, 16'h0000);
    `CHK(gate_dac_code[0], 12'hABC)
    wr(5'h00, 16'h0018);
    result(12'h555, 12'h555);
    wr(5'h03, 16'h0004);
    smp(1'b0, 12'h200, 1'b1);
    smp(1'b0, 12'h202, 1'b0);
    smp(1'b0, 12'h205, 1'b1);
    `CHK(temp_value[0], 12'h205)
    wr(5'h00, 16'h0000);
    wr(5'h02, 16'h0003);
    wr(5'h00, 16'h000A);
    smp(1'b1, 12'h100, 1'b1);
    smp(1'b1, 12'h103, 1'b0);
    smp(1'b1, 12'h104, 1'b1);
    wr(5'h0A, 16'hFF85);
    `CHK({adc_start, adc_continuous, adc_channel_enable}, {2'b11, 7'h05})
    @(posedge mclk);
    ch_powered_down <= 2'b01;
    wr(5'h09, 16'hFFFA);
    `CHK(nvm_cal_image, 3'h2)
    wait_cal(2'b10, 1'b0);
    repeat (2) @(negedge mclk);
    rd(5'h12, 16'h0000);
    @(posedge mclk);
    ch_powered_down <= 2'b00;
    wr(5'h09, 16'h0003);
    wait_cal(2'b11, 1'b1);
    wr(5'h09, 16'h0006);
    wait_cal(2'b11, 1'b0);
    wait_cal(2'b11, 1'b0);
    `CHK(k >= CAL_CYC && k <= CAL_CYC + 2, 1'b1)
    `CHK(nvm_cal_image, 3'h6)
    wr(5'h09, 16'h0000);
    avg(12'h300, 16'h0000);
    wr(5'h01, 16'h0001);
    wr(5'h00, 16'h1000);
    avg(12'h100, 16'h0100);
    avg(12'h180, 16'h0100);
    wr(5'h00, 16'hB000);
    avg(12'h180, 16'h0101);
    wr(5'h00, 16'hE000);
    avg(12'h021, 16'h00F2);
    report_and_stop();
  end
endmodule
